// ===== core/dfa_pkg.sv
// Arbiter constants
package dfa_pkg;
    // Fabric port modes
    localparam logic [1:0] MODE_AXI64    = 2'h0;
    localparam logic [1:0] MODE_AHB_ONE  = 2'h1;
    localparam logic [1:0] MODE_AHB_DUAL = 2'h2;

    // Processor request classes
    localparam logic [1:0] CLS_ICACHE = 2'h0;
    localparam logic [1:0] CLS_SYSBUS = 2'h1;
    localparam logic [1:0] CLS_DMA    = 2'h2;

    // Arbiter sources
    localparam logic SRC_PROC = 1'b0;
    localparam logic SRC_FAB  = 1'b1;

    // Index 0 icache rd .. 6 fabric wr; 1 highest
    localparam logic [6:0][2:0] PRI_LG_TYPE0 = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
    localparam logic [6:0][2:0] PRI_LG_TYPE1 = {3'h6, 3'h7, 3'h5, 3'h3, 3'h4, 3'h3, 3'h2};
    localparam logic [6:0][2:0] PRI_LG_TYPE2 = {3'h6, 3'h7, 3'h5, 3'h1, 3'h4, 3'h3, 3'h2};
    // Small variant: proc rd, fabric rd, proc wr, fabric wr
    localparam logic [3:0][2:0] PRI_SM_TYPE0 = {3'h4, 3'h3, 3'h2, 3'h1};
    localparam logic [3:0][2:0] PRI_SM_TYPE1 = {3'h3, 3'h4, 3'h1, 3'h2};

    // Lock counter width, read queue depth
    localparam int unsigned LOCK_CNT_W = 20;
    localparam int unsigned RD_QUEUE_DEPTH = 4;

    // Clock ratio factors
    localparam logic [1:0] BASE_X1 = 2'h0;
    localparam logic [1:0] BASE_X2 = 2'h1;
    localparam logic [1:0] BASE_X3 = 2'h3;
    localparam logic [2:0] FAB_X1  = 3'h0;
    localparam logic [2:0] FAB_X2  = 3'h1;
    localparam logic [2:0] FAB_X4  = 3'h2;
    localparam logic [2:0] FAB_X8  = 3'h4;
    localparam logic [2:0] FAB_X16 = 3'h5;
endpackage

// ===== core/dfa_port_if.sv
// Slave port to priority block link
`timescale 1ns/1ps
`default_nettype none
interface dfa_port_if #(
    parameter int AW  = 32,
    parameter int IDW = 4
);
    logic           rd_valid;
    logic [IDW-1:0] rd_id;
    logic [AW-1:0]  rd_addr;
    logic [1:0]     rd_cls;
    logic           rd_pop;
    logic           wr_valid;
    logic [IDW-1:0] wr_id;
    logic [AW-1:0]  wr_addr;
    logic [1:0]     wr_cls;
    logic           wr_pop;
    logic           wr_done;

    modport port (output rd_valid, rd_id, rd_addr, rd_cls, wr_valid, wr_id, wr_addr, wr_cls,
                  input rd_pop, wr_pop, wr_done);
    modport arb  (input rd_valid, rd_id, rd_addr, rd_cls, wr_valid, wr_id, wr_addr, wr_cls,
                  output rd_pop, wr_pop, wr_done);
endinterface
`default_nettype wire

// ===== core/dfa_slave_port.sv
// Slave port: read queue, one write slot
`timescale 1ns/1ps
`default_nettype none
module dfa_slave_port #(
    parameter int AW    = 32,
    parameter int IDW   = 4,
    parameter int DEPTH = dfa_pkg::RD_QUEUE_DEPTH
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // Accept next cycle
    input  wire logic           en_i,
    // Read address channel
    input  wire logic           ar_valid_i,
    input  wire logic [IDW-1:0] ar_id_i,
    input  wire logic [AW-1:0]  ar_addr_i,
    input  wire logic [1:0]     ar_cls_i,
    output logic                ar_ready_o,
    // Write address channel
    input  wire logic           aw_valid_i,
    input  wire logic [IDW-1:0] aw_id_i,
    input  wire logic [AW-1:0]  aw_addr_i,
    input  wire logic [1:0]     aw_cls_i,
    output logic                aw_ready_o,
    // Write response
    output logic                b_valid_o,
    output logic [IDW-1:0]      b_id_o,
    // Toward the priority block
    dfa_port_if.port            p
);
    localparam int PW = $clog2(DEPTH);

    logic [IDW-1:0] q_id_q   [DEPTH];
    logic [AW-1:0]  q_addr_q [DEPTH];
    logic [1:0]     q_cls_q  [DEPTH];
    logic [PW-1:0]  wp_q, rp_q;
    logic [PW:0]    cnt_q, cnt_d;
    logic           push, pop;
    logic           wfull_q, wissued_q, wfull_d;
    logic [IDW-1:0] w_id_q;
    logic [AW-1:0]  w_addr_q;
    logic [1:0]     w_cls_q;

    assign push  = ar_valid_i & ar_ready_o;
    assign pop   = p.rd_pop & (cnt_q != '0);
    assign cnt_d = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

    // Plain FIFO keeps same-ID order
    always_ff @(posedge clk_i) begin
        if (push) begin
            q_id_q[wp_q]   <= ar_id_i;
            q_addr_q[wp_q] <= ar_addr_i;
            q_cls_q[wp_q]  <= ar_cls_i;
        end
    end

    // Pointers; ready from next fill
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_q       <= '0;
            rp_q       <= '0;
            cnt_q      <= '0;
            ar_ready_o <= 1'b0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop)  rp_q <= rp_q + 1'b1;
            cnt_q      <= cnt_d;
            ar_ready_o <= en_i && (cnt_d < (PW+1)'(DEPTH));
        end
    end

    assign p.rd_valid = (cnt_q != '0);
    assign p.rd_id    = q_id_q[rp_q];
    assign p.rd_addr  = q_addr_q[rp_q];
    assign p.rd_cls   = q_cls_q[rp_q];

    // Write slot held until done
    assign wfull_d = (wfull_q & ~p.wr_done) | (aw_valid_i & aw_ready_o);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wfull_q    <= 1'b0;
            wissued_q  <= 1'b0;
            aw_ready_o <= 1'b0;
            b_valid_o  <= 1'b0;
            b_id_o     <= '0;
            w_id_q     <= '0;
            w_addr_q   <= '0;
            w_cls_q    <= '0;
        end else begin
            wfull_q    <= wfull_d;
            aw_ready_o <= en_i & ~wfull_d;
            b_valid_o  <= wfull_q & p.wr_done;
            b_id_o     <= w_id_q;
            if (aw_valid_i & aw_ready_o) begin
                w_id_q    <= aw_id_i;
                w_addr_q  <= aw_addr_i;
                w_cls_q   <= aw_cls_i;
                wissued_q <= 1'b0;
            end else if (p.wr_pop) begin
                wissued_q <= 1'b1;
            end
        end
    end

    assign p.wr_valid = wfull_q & ~wissued_q;
    assign p.wr_id    = w_id_q;
    assign p.wr_addr  = w_addr_q;
    assign p.wr_cls   = w_cls_q;
endmodule
`default_nettype wire

// ===== core/dfa_top.sv
// Fabric port, AHB bridge, lock watchdog, priority
// Operation
// - AXI mode passes fabric transactions, locks included
// - Locked transfer timed by 20-bit down counter
// - Counter expiry gives one-cycle timeout pulse
// - AHB modes convert 32-bit transfers to AXI
// - Dual AHB masters served round robin
// - Fabric side paced by ratio-related fabric clock
// - Ratio is base factor times fabric factor
// - Accept both ports, issue handler commands
// - Two separate AXI slave ports
// - Same ID completes in issue order
// - Separate read port queues four reads
// - Write port holds one write, handshakes
// - Default: reads first, processor before fabric
// - Promotion only for matching ID, nonzero scheme
// - Large variant seven-level priority table
// - Small variant four-level priority table
`timescale 1ns/1ps
`default_nettype none
module dfa_top #(
    parameter int AW    = 32,
    parameter int IDW   = 4,
    parameter bit LARGE = 1'b1
) (
    // Clock and reset
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    // Configuration
    input  wire logic [1:0]     fab_mode_i,
    input  wire logic [1:0]     base_divider_select_i,
    input  wire logic [2:0]     fabric_divider_select_i,
    input  wire logic [1:0]     priority_scheme_i,
    input  wire logic [IDW-1:0] promoted_master_id_i,
    input  wire logic [dfa_pkg::LOCK_CNT_W-1:0] lock_timeout_cfg_i,
    // Processor-side bridge port
    input  wire logic           prc_ar_valid_i,
    input  wire logic [IDW-1:0] prc_ar_id_i,
    input  wire logic [AW-1:0]  prc_ar_addr_i,
    input  wire logic [1:0]     prc_ar_cls_i,
    output logic                prc_ar_ready_o,
    input  wire logic           prc_aw_valid_i,
    input  wire logic [IDW-1:0] prc_aw_id_i,
    input  wire logic [AW-1:0]  prc_aw_addr_i,
    input  wire logic [1:0]     prc_aw_cls_i,
    output logic                prc_aw_ready_o,
    output logic                prc_b_valid_o,
    output logic [IDW-1:0]      prc_b_id_o,
    // Fabric AXI-64 port
    input  wire logic           fab_ar_valid_i,
    input  wire logic [IDW-1:0] fab_ar_id_i,
    input  wire logic [AW-1:0]  fab_ar_addr_i,
    output logic                fab_ar_ready_o,
    input  wire logic           fab_aw_valid_i,
    input  wire logic [IDW-1:0] fab_aw_id_i,
    input  wire logic [AW-1:0]  fab_aw_addr_i,
    output logic                fab_aw_ready_o,
    output logic                fab_b_valid_o,
    output logic [IDW-1:0]      fab_b_id_o,
    input  wire logic           fab_lock_i,
    output logic                lock_timeout_o,
    // Fabric AHB-Lite masters
    input  wire logic [1:0]     ahb_valid_i,
    input  wire logic [1:0]     ahb_write_i,
    input  wire logic [1:0][AW-1:0] ahb_addr_i,
    output logic [1:0]          ahb_ready_o,
    // Clock ratio status
    output logic [4:0]          clock_ratio_o,
    output logic                clock_ratio_valid_o,
    output logic                fab_tick_o,
    // Transaction handler command
    output logic                cmd_valid_o,
    output logic                cmd_write_o,
    output logic                cmd_src_o,
    output logic [IDW-1:0]      cmd_id_o,
    output logic [AW-1:0]       cmd_addr_o,
    input  wire logic           cmd_ready_i,
    input  wire logic           cmd_wr_done_i
);
    typedef enum logic [0:0] {
        ARB_IDLE = 1'b0,
        ARB_BUSY = 1'b1
    } dfa_arb_state_t;

    dfa_port_if #(.AW(AW), .IDW(IDW)) prc_if ();
    dfa_port_if #(.AW(AW), .IDW(IDW)) fab_if ();

    // Ratio from both selects
    logic [1:0] base_f;
    logic [4:0] fab_f;
    logic       ratio_ok;
    always_comb begin
        base_f   = 2'h1;
        fab_f    = 5'h01;
        ratio_ok = 1'b1;
        case (base_divider_select_i)
            dfa_pkg::BASE_X1: base_f = 2'h1;
            dfa_pkg::BASE_X2: base_f = 2'h2;
            dfa_pkg::BASE_X3: base_f = 2'h3;
            default:          ratio_ok = 1'b0;
        endcase
        case (fabric_divider_select_i)
            dfa_pkg::FAB_X1:  fab_f = 5'h01;
            dfa_pkg::FAB_X2:  fab_f = 5'h02;
            dfa_pkg::FAB_X4:  fab_f = 5'h04;
            dfa_pkg::FAB_X8:  fab_f = 5'h08;
            dfa_pkg::FAB_X16: begin
                fab_f    = 5'h10;
                ratio_ok = ratio_ok && (base_divider_select_i == dfa_pkg::BASE_X1);
            end
            default:          ratio_ok = 1'b0;
        endcase
        if (base_f == 2'h3 && fab_f > 5'h04) ratio_ok = 1'b0;
    end

    // Fabric tick every ratio cycles
    logic [4:0] phase_q, phase_d;
    logic       tick_d;
    always_comb begin
        tick_d  = (phase_q == 5'h00);
        phase_d = tick_d ? (clock_ratio_o - 5'h01) : (phase_q - 5'h01);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_ratio_o       <= 5'h01;
            clock_ratio_valid_o <= 1'b0;
            phase_q             <= 5'h00;
            fab_tick_o          <= 1'b0;
        end else begin
            clock_ratio_valid_o <= ratio_ok;
            if (ratio_ok) clock_ratio_o <= 5'(base_f * fab_f);
            phase_q    <= phase_d;
            fab_tick_o <= tick_d;
        end
    end

    // AHB bridge, one pending request
    logic           br_valid_q, br_write_q, br_last_q;
    logic [AW-1:0]  br_addr_q;
    logic           br_taken, br_pick;
    logic [1:0]     br_req;
    logic           ahb_mode;
    assign ahb_mode = (fab_mode_i != dfa_pkg::MODE_AXI64);
    assign br_req   = (fab_mode_i == dfa_pkg::MODE_AHB_DUAL) ? ahb_valid_i
                                                              : {1'b0, ahb_valid_i[0]};
    assign br_pick  = br_req[1] & (~br_req[0] | ~br_last_q);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            br_valid_q  <= 1'b0;
            br_write_q  <= 1'b0;
            br_last_q   <= 1'b1;
            br_addr_q   <= '0;
            ahb_ready_o <= 2'h0;
        end else begin
            ahb_ready_o <= 2'h0;
            if (br_taken) br_valid_q <= 1'b0;
            if (ahb_mode && !br_valid_q && fab_tick_o && br_req != 2'h0) begin
                br_valid_q  <= 1'b1;
                br_write_q  <= ahb_write_i[br_pick];
                br_addr_q   <= ahb_addr_i[br_pick];
                br_last_q   <= br_pick;
                ahb_ready_o <= br_pick ? 2'h2 : 2'h1;
            end
        end
    end

    // Fabric mux; AHB masters are IDs 0, 1
    logic           f_ar_valid, f_aw_valid;
    logic [IDW-1:0] f_ar_id, f_aw_id, br_id;
    logic [AW-1:0]  f_ar_addr, f_aw_addr;
    logic           f_ar_ready, f_aw_ready;
    assign br_id      = IDW'(br_last_q);
    assign f_ar_valid = ahb_mode ? (br_valid_q & ~br_write_q) : fab_ar_valid_i;
    assign f_aw_valid = ahb_mode ? (br_valid_q & br_write_q) : fab_aw_valid_i;
    assign f_ar_id    = ahb_mode ? br_id : fab_ar_id_i;
    assign f_aw_id    = ahb_mode ? br_id : fab_aw_id_i;
    assign f_ar_addr  = ahb_mode ? br_addr_q : fab_ar_addr_i;
    assign f_aw_addr  = ahb_mode ? br_addr_q : fab_aw_addr_i;
    assign br_taken   = (f_ar_valid & f_ar_ready) | (f_aw_valid & f_aw_ready);

    // Fabric readies only in AXI mode
    assign fab_ar_ready_o = f_ar_ready & ~ahb_mode;
    assign fab_aw_ready_o = f_aw_ready & ~ahb_mode;

    // Slave ports; fabric one paced by tick
    dfa_slave_port #(.AW(AW), .IDW(IDW)) u_prc_port (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .en_i       (1'b1),
        .ar_valid_i (prc_ar_valid_i),
        .ar_id_i    (prc_ar_id_i),
        .ar_addr_i  (prc_ar_addr_i),
        .ar_cls_i   (prc_ar_cls_i),
        .ar_ready_o (prc_ar_ready_o),
        .aw_valid_i (prc_aw_valid_i),
        .aw_id_i    (prc_aw_id_i),
        .aw_addr_i  (prc_aw_addr_i),
        .aw_cls_i   (prc_aw_cls_i),
        .aw_ready_o (prc_aw_ready_o),
        .b_valid_o  (prc_b_valid_o),
        .b_id_o     (prc_b_id_o),
        .p          (prc_if.port)
    );
    dfa_slave_port #(.AW(AW), .IDW(IDW)) u_fab_port (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .en_i       (tick_d),
        .ar_valid_i (f_ar_valid),
        .ar_id_i    (f_ar_id),
        .ar_addr_i  (f_ar_addr),
        .ar_cls_i   (dfa_pkg::CLS_DMA),
        .ar_ready_o (f_ar_ready),
        .aw_valid_i (f_aw_valid),
        .aw_id_i    (f_aw_id),
        .aw_addr_i  (f_aw_addr),
        .aw_cls_i   (dfa_pkg::CLS_DMA),
        .aw_ready_o (f_aw_ready),
        .b_valid_o  (fab_b_valid_o),
        .b_id_o     (fab_b_id_o),
        .p          (fab_if.port)
    );

    // Lock watchdog, AXI mode only
    logic [dfa_pkg::LOCK_CNT_W-1:0] lock_cnt_q;
    logic lock_q, lock_run_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_q         <= 1'b0;
            lock_run_q     <= 1'b0;
            lock_cnt_q     <= '0;
            lock_timeout_o <= 1'b0;
        end else begin
            lock_q         <= fab_lock_i & ~ahb_mode;
            lock_timeout_o <= 1'b0;
            if (fab_lock_i && !ahb_mode && !lock_q) begin
                lock_cnt_q <= lock_timeout_cfg_i;
                lock_run_q <= 1'b1;
            end else if (!fab_lock_i || ahb_mode) begin
                lock_run_q <= 1'b0;
            end else if (lock_run_q) begin
                lock_cnt_q <= lock_cnt_q - 1'b1;
                if (lock_cnt_q <= 20'h00001) begin
                    lock_timeout_o <= 1'b1;
                    lock_run_q     <= 1'b0;
                end
            end
        end
    end

    // Levels: proc rd, fab rd, proc wr, fab wr
    logic       promo;
    logic [2:0] pri [4];
    logic [3:0] cand;
    always_comb begin
        promo = (priority_scheme_i != 2'h0);
        if (LARGE) begin
            pri[0] = PRI_LG(promo, priority_scheme_i, {1'b0, prc_if.rd_cls});
            pri[1] = (promo && fab_if.rd_id == promoted_master_id_i)
                   ? PRI_LG(promo, priority_scheme_i, 3'h3) : 3'h4;
            pri[2] = (prc_if.wr_cls == dfa_pkg::CLS_DMA)
                   ? PRI_LG(promo, priority_scheme_i, 3'h5)
                   : PRI_LG(promo, priority_scheme_i, 3'h4);
            pri[3] = (promo && fab_if.wr_id == promoted_master_id_i)
                   ? PRI_LG(promo, priority_scheme_i, 3'h6) : 3'h7;
        end else begin
            pri[0] = promo ? dfa_pkg::PRI_SM_TYPE1[0] : dfa_pkg::PRI_SM_TYPE0[0];
            pri[1] = (promo && fab_if.rd_id == promoted_master_id_i)
                   ? dfa_pkg::PRI_SM_TYPE1[1] : dfa_pkg::PRI_SM_TYPE0[1];
            pri[2] = promo ? dfa_pkg::PRI_SM_TYPE1[2] : dfa_pkg::PRI_SM_TYPE0[2];
            pri[3] = (promo && fab_if.wr_id == promoted_master_id_i)
                   ? dfa_pkg::PRI_SM_TYPE1[3] : dfa_pkg::PRI_SM_TYPE0[3];
        end
        cand = {fab_if.wr_valid, prc_if.wr_valid, fab_if.rd_valid, prc_if.rd_valid};
    end

    function automatic logic [2:0] PRI_LG(input logic en, input logic [1:0] sch,
                                          input logic [2:0] idx);
        logic [2:0] r;
        r = dfa_pkg::PRI_LG_TYPE0[idx];
        if (en && sch == 2'h1) r = dfa_pkg::PRI_LG_TYPE1[idx];
        if (en && sch[1])      r = dfa_pkg::PRI_LG_TYPE2[idx];
        return r;
    endfunction

    // Lowest level wins; ties to earlier
    logic [1:0] win;
    logic       any;
    always_comb begin
        win = 2'h0;
        any = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (cand[i] && (!any || pri[i] < pri[win])) begin
                win = 2'(i);
                any = 1'b1;
            end
        end
    end

    // One command at a time, popped on issue
    dfa_arb_state_t st_q;
    logic           wr_src_q;
    assign prc_if.rd_pop  = (st_q == ARB_IDLE) && any && (win == 2'h0);
    assign fab_if.rd_pop  = (st_q == ARB_IDLE) && any && (win == 2'h1);
    assign prc_if.wr_pop  = (st_q == ARB_IDLE) && any && (win == 2'h2);
    assign fab_if.wr_pop  = (st_q == ARB_IDLE) && any && (win == 2'h3);
    assign prc_if.wr_done = cmd_wr_done_i && (wr_src_q == dfa_pkg::SRC_PROC);
    assign fab_if.wr_done = cmd_wr_done_i && (wr_src_q == dfa_pkg::SRC_FAB);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q        <= ARB_IDLE;
            cmd_valid_o <= 1'b0;
            cmd_write_o <= 1'b0;
            cmd_src_o   <= 1'b0;
            cmd_id_o    <= '0;
            cmd_addr_o  <= '0;
            wr_src_q    <= 1'b0;
        end else begin
            case (st_q)
                ARB_IDLE: begin
                    if (any) begin
                        st_q        <= ARB_BUSY;
                        cmd_valid_o <= 1'b1;
                        cmd_write_o <= win[1];
                        cmd_src_o   <= win[0];
                        if (win[1]) wr_src_q <= win[0];
                        case (win)
                            2'h0:    cmd_id_o <= prc_if.rd_id;
                            2'h1:    cmd_id_o <= fab_if.rd_id;
                            2'h2:    cmd_id_o <= prc_if.wr_id;
                            default: cmd_id_o <= fab_if.wr_id;
                        endcase
                        case (win)
                            2'h0:    cmd_addr_o <= prc_if.rd_addr;
                            2'h1:    cmd_addr_o <= fab_if.rd_addr;
                            2'h2:    cmd_addr_o <= prc_if.wr_addr;
                            default: cmd_addr_o <= fab_if.wr_addr;
                        endcase
                    end
                end
                ARB_BUSY: begin
                    if (cmd_ready_i) begin
                        st_q        <= ARB_IDLE;
                        cmd_valid_o <= 1'b0;
                    end
                end
                default: st_q <= ARB_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tb/dfa_properties.sv
// Port checks for the arbiter
`timescale 1ns/1ps
`default_nettype none
module dfa_properties #(parameter int IDW = 4) (
    // Clock, reset and configuration
    input wire logic           clk_i,
    input wire logic           rst_i,
    input wire logic [1:0]     fab_mode_i,
    input wire logic [1:0]     base_divider_select_i,
    // Lock, command and responses
    input wire logic           fab_lock_i,
    input wire logic           lock_timeout_o,
    input wire logic           prc_b_valid_o,
    input wire logic           cmd_wr_done_i,
    input wire logic           cmd_valid_o,
    input wire logic           cmd_ready_i,
    input wire logic [IDW-1:0] cmd_id_o,
    input wire logic           fab_ar_ready_o,
    input wire logic           clock_ratio_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // One-cycle pulses with a cause
    property p_lock_pulse; lock_timeout_o |=> !lock_timeout_o; endproperty
    property p_lock_cause; lock_timeout_o |-> $past(fab_lock_i); endproperty
    property p_b_cause; prc_b_valid_o |-> $past(cmd_wr_done_i); endproperty
    property p_b_pulse; prc_b_valid_o |=> !prc_b_valid_o; endproperty
    // Command held, then a gap
    property p_cmd_hold; cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_id_o); endproperty
    property p_cmd_gap; cmd_valid_o && cmd_ready_i |=> !cmd_valid_o; endproperty
    // Mode and ratio guards
    property p_fab_mode; fab_ar_ready_o |-> fab_mode_i == dfa_pkg::MODE_AXI64; endproperty
    property p_ratio_bad; $past(base_divider_select_i) == 2'h2 |-> !clock_ratio_valid_o; endproperty
    a_lock_pulse: assert property (p_lock_pulse) else $error("timeout pulse too long");
    a_lock_cause: assert property (p_lock_cause) else $error("timeout without lock");
    a_b_cause: assert property (p_b_cause) else $error("write response uncaused");
    a_b_pulse: assert property (p_b_pulse) else $error("write response too long");
    a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped");
    a_cmd_gap: assert property (p_cmd_gap) else $error("command reissued early");
    a_fab_mode: assert property (p_fab_mode) else $error("fabric ready in bridge mode");
    a_ratio_bad: assert property (p_ratio_bad) else $error("bad ratio marked valid");
    c_timeout: cover property (lock_timeout_o);
    c_wr_done: cover property (prc_b_valid_o);
    c_cmd_take: cover property (cmd_valid_o && cmd_ready_i);
endmodule
bind dfa_top dfa_properties #(.IDW(IDW)) i_dfa_properties (.*);
`default_nettype wire

// ===== tb/dfa_fab_master.sv
// Fabric read master model
`timescale 1ns/1ps
`default_nettype none
module dfa_fab_master (
    // Clock, reset and trigger
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [3:0] id_i,
    // Read address channel
    output logic            valid_o,
    output logic [3:0]      id_o,
    output logic [31:0]     addr_o,
    input  wire logic       ready_i
);
    // Released payload inverts, so stale never looks live
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            id_o    <= ~id_o;
            addr_o  <= ~addr_o;
        end else if (go_i) begin
            valid_o <= 1'b1;
            id_o    <= id_i;
            addr_o  <= {28'h0, id_i};
        end
    end
endmodule
`default_nettype wire

// ===== tb/dfa_top_tb_top.sv
// Bench for the arbiter
`timescale 1ns/1ps
`default_nettype none
module dfa_top_tb_top;
    logic clk_i, rst_i, fab_lock_i, cmd_ready_i, cmd_wr_done_i, go_rd, prc_ar_valid_i;
    logic prc_aw_valid_i, fab_aw_valid_i, prc_ar_ready_o, prc_aw_ready_o, prc_b_valid_o;
    logic fab_ar_valid_i, fab_ar_ready_o, fab_aw_ready_o, fab_b_valid_o, lock_timeout_o;
    logic clock_ratio_valid_o, fab_tick_o, cmd_valid_o, cmd_write_o, cmd_src_o;
    logic [1:0] fab_mode_i, base_divider_select_i, priority_scheme_i, prc_ar_cls_i;
    logic [1:0] prc_aw_cls_i, ahb_valid_i, ahb_write_i, ahb_ready_o;
    logic [2:0] fabric_divider_select_i;
    logic [3:0] promoted_master_id_i, prc_ar_id_i, prc_aw_id_i, fab_aw_id_i, fid;
    logic [3:0] prc_b_id_o, fab_ar_id_i, fab_b_id_o, cmd_id_o;
    logic [4:0] clock_ratio_o;
    logic [dfa_pkg::LOCK_CNT_W-1:0] lock_timeout_cfg_i;
    logic [31:0] prc_ar_addr_i, prc_aw_addr_i, fab_aw_addr_i, fab_ar_addr_i, cmd_addr_o;
    logic [31:0] mismatches, n_tests;
    logic [1:0][31:0] ahb_addr_i;
    dfa_top i_dfa_top (.*);
    dfa_fab_master i_dfa_fab_master (.clk_i, .rst_i, .go_i(go_rd), .id_i(fid),
        .valid_o(fab_ar_valid_i), .id_o(fab_ar_id_i), .addr_o(fab_ar_addr_i), .ready_i(fab_ar_ready_o));
    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && n_tests != 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Take one command, end a write
    task automatic get_cmd(input logic w, s, input logic [3:0] id);
        @(negedge clk_i);
        for (int n = 0; n < 60 && cmd_valid_o !== 1'b1; n++) @(negedge clk_i);
        if (cmd_valid_o !== 1'b1) begin
            mismatches = mismatches + 1;
            give_verdict();
        end
        check("cmd", {cmd_write_o, cmd_src_o, cmd_id_o}, {w, s, id});
        check("addr", cmd_addr_o, s ? id : 4'h0);
        @(posedge clk_i) cmd_ready_i <= 1'b1;
        @(posedge clk_i) cmd_ready_i <= 1'b0;
        cmd_wr_done_i <= w;
        @(posedge clk_i) cmd_wr_done_i <= 1'b0;
        @(negedge clk_i);
        if (w) check("b", {prc_b_valid_o, prc_b_id_o}, {1'b1, id});
    endtask
    // Read valids rise on one edge
    task automatic launch(input logic [2:0] en, input logic [1:0] cls);
        @(posedge clk_i) go_rd <= en[1];
        {prc_ar_cls_i, prc_aw_cls_i} <= {cls, cls};
        @(posedge clk_i) go_rd <= 1'b0;
        {prc_aw_valid_i, prc_ar_valid_i} <= {en[2], en[0]};
        @(posedge clk_i) {prc_aw_valid_i, prc_ar_valid_i} <= 2'b00;
    endtask
    // Selects, ratio, valid; ends 1:1
    task automatic t_ratio;
        logic [10:0] tv [7];
        tv = '{11'h161, 11'h321, 11'h699, 11'h64d, 11'h340, 11'h400, 11'h003};
        foreach (tv[i]) begin
            @(posedge clk_i) {base_divider_select_i, fabric_divider_select_i} <= tv[i][10:6];
            repeat (4) @(negedge clk_i);
            check("ratio valid", clock_ratio_valid_o, tv[i][0]);
            if (tv[i][0]) check("ratio", clock_ratio_o, tv[i][5:1]);
        end
    endtask
    // Scheme, ID, class, fabric first
    task automatic t_promo;
        logic [8:0] tv [4];
        logic       f;
        tv = '{9'h12b, 9'h132, 9'h0ad, 9'h02c};
        promoted_master_id_i <= 4'h5;
        foreach (tv[i]) begin
            @(posedge clk_i) {priority_scheme_i, fid} <= tv[i][8:3];
            f = tv[i][0];
            launch(3'h3, tv[i][2:1]);
            get_cmd(1'b0, f, f ? fid : 4'h1);
            get_cmd(1'b0, !f, f ? 4'h1 : fid);
        end
    endtask
    // Count timeouts over a lock
    task automatic lock_run(input int len, input logic [7:0] exp);
        logic [7:0] p;
        p = 8'h0;
        for (int i = 0; i < len + 4; i++) begin
            @(posedge clk_i) fab_lock_i <= (i < len);
            @(negedge clk_i);
            p = p + lock_timeout_o;
        end
        check("timeouts", p, exp);
    endtask
    initial begin
        {mismatches, n_tests, fab_mode_i, base_divider_select_i, fabric_divider_select_i} = '0;
        {priority_scheme_i, promoted_master_id_i, fab_lock_i, cmd_ready_i, cmd_wr_done_i} = '0;
        {go_rd, prc_ar_valid_i, prc_aw_valid_i, fab_aw_valid_i, ahb_valid_i, ahb_write_i} = '0;
        {prc_ar_addr_i, prc_aw_addr_i, fab_aw_addr_i, fab_aw_id_i, ahb_addr_i} = '0;
        {prc_ar_cls_i, prc_aw_cls_i, prc_ar_id_i, prc_aw_id_i, fid} = {4'h0, 12'h132};
        lock_timeout_cfg_i = 20'h5;
        rst_i = 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ratio();
        launch(3'h7, 2'h1);
        get_cmd(1'b0, 1'b0, 4'h1);
        get_cmd(1'b0, 1'b1, 4'h2);
        get_cmd(1'b1, 1'b0, 4'h3);
        t_promo();
        lock_run(30, 8'h1);
        lock_run(3, 8'h0);
        lock_run(30, 8'h1);
        @(posedge clk_i) {fab_mode_i, ahb_valid_i, ahb_addr_i} <= {2'h2, 2'h3, 64'h1_0000_0000};
        get_cmd(1'b0, 1'b1, 4'h0);
        get_cmd(1'b0, 1'b1, 4'h1);
        give_verdict();
    end
endmodule
`default_nettype wire
